/* File: hw/button_debounce.sv */
// Synchroniser, debouncer and press-edge detector for one pushbutton.
// Assumes an asynchronous active-high button level.
`timescale 1ns/100ps
module button_debounce #(
  parameter int unsigned STABLE_CYC = 32'd5000000
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Button
  input  wire logic btnRaw,
  output logic      level,
  output logic      pressPulse
);
  logic        sync1_reg;
  logic        sync2_reg;
  logic [31:0] cnt_reg;

  // Two-stage synchroniser; only stage two is looked at
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= btnRaw;
      sync2_reg <= sync1_reg;
    end
  end

  // Accept a new level only after it holds for the full window
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      cnt_reg    <= 32'h0;
      level      <= 1'b0;
      pressPulse <= 1'b0;
    end
    else
    begin
      pressPulse <= 1'b0;
      if (sync2_reg == level)
        cnt_reg <= 32'h0;
      else if (cnt_reg >= STABLE_CYC - 1)
      begin
        cnt_reg    <= 32'h0;
        level      <= sync2_reg;
        pressPulse <= sync2_reg;
      end
      else
        cnt_reg <= cnt_reg + 32'h1;
    end
  end
endmodule // button_debounce

/* File: hw/bypass_transfer_controller.sv */
// Maintenance bypass transfer sequencer and interlock.
// Assumes breaker aux contacts, voltage sensors and unit bypass flags are async pins.
`timescale 1ns/100ps
`include "bypass_xfer_defs.svh"
module bypass_transfer_controller #(
  parameter int unsigned NUM_UNITS    = 7,
  parameter int unsigned OVERLAP_CYC  = `OVERLAP_LIMIT_CYC,
  parameter int unsigned RESPONSE_CYC = `BKR_RESPONSE_CYC,
  parameter int unsigned DEBOUNCE_CYC = `DEBOUNCE_CYC,
  parameter int unsigned BLINK_CYC    = `BLINK_CYC
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rstn,
  // Operator buttons
  input  wire logic                        enterBypassBtn,
  input  wire logic                        returnLoadBtn,
  // Plant feedback
  input  wire bypass_xfer_pkg::bkr_status_t plantIn,
  input  wire logic [NUM_UNITS-1:0]        unitInBypass,
  // Breaker commands (level: close / trip coil request)
  output logic                             bypassCloseCmd,
  output logic                             bypassTripCmd,
  output logic                             isoCloseCmd,
  output logic                             isoTripCmd,
  // Indicators
  output bypass_xfer_pkg::lamps_t          lamps,
  output bypass_xfer_pkg::xfer_state_t     xferState
);
  import bypass_xfer_pkg::*;

  bkr_status_t           plantS1_reg;
  bkr_status_t           plant_reg;
  logic [NUM_UNITS-1:0]  unitS1_reg;
  logic [NUM_UNITS-1:0]  unit_reg;
  logic                  enterLvl;
  logic                  enterPress;
  logic                  returnLvl;
  logic                  returnPress;
  logic                  toBypass_reg;   // Direction of the active sequence
  logic                  lastEnter_reg;  // Last pressed button was enter-bypass
  logic [31:0]           stepCnt_reg;
  logic [31:0]           overlapCnt_reg;
  logic [31:0]           blinkCnt_reg;
  logic                  blink_reg;
  logic                  overlapTrip_reg;
  logic                  deadBus;
  logic                  srcBad;
  logic                  allUnitsBypass;
  logic                  newClosed;
  logic                  oldClosed;
  logic                  newLineOk;
  xfer_state_t           state_next;

  // Steps that pull a breaker in; shared by both close coils
  function automatic logic isMakeStep(input xfer_state_t st);
    isMakeStep = (st == CLOSE_NEW) || (st == MAKE_NEW);
  endfunction

  // Steps that push a breaker out; shared by both trip coils
  function automatic logic isBreakStep(input xfer_state_t st);
    isBreakStep = (st == OPEN_OLD) || (st == BREAK_OLD);
  endfunction

  // Both buttons share one debounce design
  button_debounce #(.STABLE_CYC(DEBOUNCE_CYC)) enterDb (
    .clk        (clk),
    .rstn       (rstn),
    .btnRaw     (enterBypassBtn),
    .level      (enterLvl),
    .pressPulse (enterPress)
  );

  button_debounce #(.STABLE_CYC(DEBOUNCE_CYC)) returnDb (
    .clk        (clk),
    .rstn       (rstn),
    .btnRaw     (returnLoadBtn),
    .level      (returnLvl),
    .pressPulse (returnPress)
  );

  // Plant pins come from outside the clock domain
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      plantS1_reg <= '0;
      plant_reg   <= '0;
      unitS1_reg  <= '0;
      unit_reg    <= '0;
    end
    else
    begin
      plantS1_reg <= plantIn;
      plant_reg   <= plantS1_reg;
      unitS1_reg  <= unitInBypass;
      unit_reg    <= unitS1_reg;
    end
  end

  // Derived conditions
  assign allUnitsBypass = &unit_reg;
  assign deadBus = !plant_reg.outputLive
                   && (plant_reg.bypassClosed || plant_reg.isoClosed);
  assign srcBad  = (plant_reg.bypassClosed && !plant_reg.bypassLineOk)
                   || (plant_reg.isoClosed && !plant_reg.isoLineOk) || deadBus;
  assign newClosed = toBypass_reg ? plant_reg.bypassClosed : plant_reg.isoClosed;
  assign oldClosed = toBypass_reg ? plant_reg.isoClosed : plant_reg.bypassClosed;
  assign newLineOk = toBypass_reg ? plant_reg.bypassLineOk : plant_reg.isoLineOk;

  // Sequencer next state
  always_comb
  begin
    state_next = xferState;
    case (xferState)
      IDLE:
      begin
        if ((enterPress && lamps.enterBypassLamp && allUnitsBypass)
            || (returnPress && lamps.returnLoadLamp))
          state_next = srcBad ? BREAK_OLD : CLOSE_NEW;
      end
      CLOSE_NEW:
      begin
        if (newClosed)
          state_next = OPEN_OLD;
        else if (stepCnt_reg >= RESPONSE_CYC - 1 || !newLineOk)
          state_next = FAILED;
      end
      OPEN_OLD:
      begin
        if (!oldClosed)
          state_next = IDLE;
        else if (stepCnt_reg >= RESPONSE_CYC - 1)
          state_next = FAILED;
      end
      BREAK_OLD:
      begin
        if (!oldClosed)
          state_next = MAKE_NEW;
        else if (stepCnt_reg >= RESPONSE_CYC - 1)
          state_next = FAILED;
      end
      MAKE_NEW:
      begin
        if (newClosed)
          state_next = IDLE;
        else if (stepCnt_reg >= RESPONSE_CYC - 1 || !newLineOk)
          state_next = FAILED;
      end
      FAILED:
      begin
        // Only the non-blinking button clears the failure
        if ((lastEnter_reg && returnPress) || (!lastEnter_reg && enterPress))
          state_next = IDLE;
      end
      default: state_next = IDLE;
    endcase
  end

  // State and step timer
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      xferState   <= IDLE;
      stepCnt_reg <= 32'h0;
    end
    else
    begin
      xferState   <= state_next;
      stepCnt_reg <= (state_next != xferState) ? 32'h0 : stepCnt_reg + 32'h1;
    end
  end

  // Direction and last-pressed memory
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      toBypass_reg  <= 1'b0;
      lastEnter_reg <= 1'b0;
    end
    else if (xferState == IDLE && state_next != IDLE)
    begin
      // A refused enter press must not steer a return started in the same cycle
      toBypass_reg  <= enterPress && lamps.enterBypassLamp && allUnitsBypass;
      lastEnter_reg <= enterPress && lamps.enterBypassLamp && allUnitsBypass;
    end
  end

  // Independent overlap watchdog, kept apart from the sequencer on purpose
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      overlapCnt_reg  <= 32'h0;
      overlapTrip_reg <= 1'b0;
    end
    else if (plant_reg.bypassClosed && plant_reg.isoClosed)
    begin
      if (overlapCnt_reg >= OVERLAP_CYC)
        overlapTrip_reg <= 1'b1;
      else
        overlapCnt_reg <= overlapCnt_reg + 32'h1;
    end
    else
    begin
      overlapCnt_reg  <= 32'h0;
      overlapTrip_reg <= 1'b0;
    end
  end

  // Breaker coils; closes gated by line voltage, direction and make step
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      bypassCloseCmd <= 1'b0;
      isoCloseCmd    <= 1'b0;
      bypassTripCmd  <= 1'b0;
      isoTripCmd     <= 1'b0;
    end
    else
    begin
      // Close the incoming breaker only with good line voltage
      bypassCloseCmd <= toBypass_reg && plant_reg.bypassLineOk
                        && isMakeStep(xferState);
      isoCloseCmd    <= !toBypass_reg && plant_reg.isoLineOk
                        && isMakeStep(xferState);
      // Open the outgoing breaker after make, or first when break-before-make
      bypassTripCmd  <= !toBypass_reg && isBreakStep(xferState);
      isoTripCmd     <= overlapTrip_reg
                        || (toBypass_reg && isBreakStep(xferState));
      // A stuck-closed old breaker: open the new one instead
      if (xferState == OPEN_OLD && state_next == FAILED)
      begin
        bypassTripCmd <= toBypass_reg;
        isoTripCmd    <= !toBypass_reg;
      end
    end
  end

  // Blink timebase as a square wave toggling every BLINK_CYC cycles
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      blinkCnt_reg <= 32'h0;
      blink_reg    <= 1'b0;
    end
    else if (blinkCnt_reg >= BLINK_CYC - 1)
    begin
      blinkCnt_reg <= 32'h0;
      blink_reg    <= !blink_reg;
    end
    else
      blinkCnt_reg <= blinkCnt_reg + 32'h1;
  end

  // Lamps; a failure blinks the last pressed button lamp and holds the other on
  always_ff @(posedge clk)
  begin
    if (!rstn)
      lamps <= '0;
    else
    begin
      lamps.xferFailLamp  <= (state_next == FAILED);
      lamps.breakXferLamp <= srcBad;
      if (state_next == FAILED)
      begin
        lamps.enterBypassLamp <= lastEnter_reg ? blink_reg : 1'b1;
        lamps.returnLoadLamp  <= lastEnter_reg ? 1'b1 : blink_reg;
      end
      else
      begin
        lamps.enterBypassLamp <= plant_reg.isoClosed;
        lamps.returnLoadLamp  <= plant_reg.bypassClosed;
      end
    end
  end

  // Levels are kept for completeness of the debouncers; presses drive behaviour
  logic unusedLvl;
  assign unusedLvl = enterLvl ^ returnLvl;

endmodule // bypass_transfer_controller

/* File: hw/bypass_xfer_defs.svh */
// Constants for the maintenance bypass transfer interlock.
// Assumes a 250 MHz system clock; included by the transfer controller module only.
// How it works
// - Enter bypass: close bypass breaker, then open isolation breaker, overlapping.
// - Return: close isolation breaker, then open bypass breaker, overlapping.
// - Enter bypass refused until every paralleled unit reports internal bypass.
// - A breaker failing to close leaves the other closed and lights failure lamp.
// - A breaker failing to open gets the other opened and lights failure lamp.
// - While failure lamp lit, the last pressed button lamp blinks.
// - Only a press of the non-blinking button clears the failure lamp.
// - No close command without valid line voltage at that breaker.
// - Independent timer trips isolation breaker after both closed over 4 s.
// - Open-transition lamp lights when the closed breaker's source is invalid.
// - With that lamp lit, lit button press trips closed breaker before closing.
// - Open-transition lamp lights when output is dead behind either closed breaker.
// - Dead bus inhibits overlapping transfers.
// - Enter-bypass button lit while isolation breaker closed.
// - Return-to-load button lit while bypass breaker closed.
// - Breaker combinations that back-feed the utility are blocked; no interlock for this, closes gated by step and line voltage only.
`ifndef BYPASS_XFER_DEFS_SVH
`define BYPASS_XFER_DEFS_SVH

`define CLK_MHZ          250
`define OVERLAP_LIMIT_MS 4000
`define OVERLAP_LIMIT_CYC (`OVERLAP_LIMIT_MS * 1000 * `CLK_MHZ)
`define BKR_RESPONSE_MS  500
`define BKR_RESPONSE_CYC (`BKR_RESPONSE_MS * 1000 * `CLK_MHZ)
`define DEBOUNCE_MS      20
`define DEBOUNCE_CYC     (`DEBOUNCE_MS * 1000 * `CLK_MHZ)
`define BLINK_MS         250
`define BLINK_CYC        (`BLINK_MS * 1000 * `CLK_MHZ)

`endif

/* File: hw/bypass_xfer_pkg.sv */
// Types shared by the transfer interlock modules.
// Assumes the constants header sits beside it.
package bypass_xfer_pkg;

  // Breaker feedback and line-side voltage validity
  typedef struct packed {
    logic bypassClosed;
    logic isoClosed;
    logic bypassLineOk;
    logic isoLineOk;
    logic outputLive;
  } bkr_status_t;

  // Lamp drives
  typedef struct packed {
    logic enterBypassLamp;
    logic returnLoadLamp;
    logic xferFailLamp;
    logic breakXferLamp;
  } lamps_t;

  // Transfer sequencer states
  typedef enum logic [2:0] {
    IDLE       = 3'b000,
    CLOSE_NEW  = 3'b001,
    OPEN_OLD   = 3'b010,
    BREAK_OLD  = 3'b011,
    MAKE_NEW   = 3'b100,
    FAILED     = 3'b101
  } xfer_state_t;

endpackage

/* File: tb/breaker_model.sv */
// Behavioural motor-operated breaker with aux contact and stuck-mechanism fault.
// Assumes coil requests are levels from the controller, same clock.
`timescale 1ns/100ps
module breaker_model #(
  parameter logic INIT = 1'h0,
  parameter int   DLY  = 6
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Coils and fault injection
  input  wire logic closeCmd,
  input  wire logic tripCmd,
  input  wire logic stuck,
  // Aux contact
  output logic      closed
);
  logic [3:0] cnt;
  logic       goal;

  // Mechanism travel time; a stuck breaker swallows the stroke, even a one-cycle trip
  always_ff @(posedge clk)
    if (!rstn)
    begin
      closed <= INIT;
      cnt    <= 4'h0;
      goal   <= INIT;
    end
    else if (cnt != 4'h0)
    begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h1 && !stuck)
        closed <= goal;
    end
    else if (closeCmd ^ tripCmd)
    begin
      cnt  <= 4'(DLY);
      goal <= closeCmd;
    end
endmodule // breaker_model

/* File: tb/bypass_transfer_controller_checker.sv */
// Concurrent checks on the transfer interlock ports.
// Assumes the plant inputs are settled levels; bound into the controller below.
`timescale 1ns/100ps
module bypass_transfer_controller_checker #(
  parameter int unsigned NUM_UNITS   = 7,
  parameter int unsigned OVERLAP_CYC = 200
) (
  input wire logic                         clk,
  input wire logic                         rstn,
  input wire logic                         enterBypassBtn,
  input wire logic                         returnLoadBtn,
  input wire bypass_xfer_pkg::bkr_status_t plantIn,
  input wire logic [NUM_UNITS-1:0]         unitInBypass,
  input wire logic                         bypassCloseCmd,
  input wire logic                         bypassTripCmd,
  input wire logic                         isoCloseCmd,
  input wire logic                         isoTripCmd,
  input wire bypass_xfer_pkg::lamps_t      lamps,
  input wire bypass_xfer_pkg::xfer_state_t xferState
);
  import bypass_xfer_pkg::*;
  logic [31:0] bothCnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Length of the current overlap, seen on the raw aux contacts
  always_ff @(posedge clk)
    if (!rstn || !(plantIn.bypassClosed && plantIn.isoClosed))
      bothCnt <= 32'h0;
    else
      bothCnt <= bothCnt + 32'h1;

  property p_bypLine; (!plantIn.bypassLineOk) [*6] |-> !bypassCloseCmd; endproperty
  a_bypLine: assert property (p_bypLine) else $error("bypass close without line");
  property p_isoLine; (!plantIn.isoLineOk) [*6] |-> !isoCloseCmd; endproperty
  a_isoLine: assert property (p_isoLine) else $error("iso close without line");
  property p_dualClose; !(bypassCloseCmd && isoCloseCmd); endproperty
  a_dualClose: assert property (p_dualClose) else $error("both closes at once");
  property p_units; (!(&unitInBypass)) [*8] |-> !$rose(bypassCloseCmd); endproperty
  a_units: assert property (p_units) else $error("enter without all units");
  property p_enterLamp;
    (plantIn.isoClosed && xferState != FAILED) [*6] |-> lamps.enterBypassLamp;
  endproperty
  a_enterLamp: assert property (p_enterLamp) else $error("enter lamp dark");
  property p_returnLamp;
    (plantIn.bypassClosed && xferState != FAILED) [*6] |-> lamps.returnLoadLamp;
  endproperty
  a_returnLamp: assert property (p_returnLamp) else $error("return lamp dark");
  property p_watchdog; bothCnt > OVERLAP_CYC + 6 |-> isoTripCmd; endproperty
  a_watchdog: assert property (p_watchdog) else $error("overlap not tripped");
  property p_openOld;
    xferState == OPEN_OLD |-> (!isoTripCmd || plantIn.bypassClosed)
      && (!bypassTripCmd || plantIn.isoClosed);
  endproperty
  a_openOld: assert property (p_openOld) else $error("trip before make");
  property p_breakOrder;
    xferState == MAKE_NEW |-> !(bypassCloseCmd && plantIn.isoClosed)
      && !(isoCloseCmd && plantIn.bypassClosed);
  endproperty
  a_breakOrder: assert property (p_breakOrder) else $error("overlap on break");
  property p_deadBus; (plantIn.bypassClosed && !plantIn.outputLive) [*6] |-> lamps.breakXferLamp;
  endproperty
  a_deadBus: assert property (p_deadBus) else $error("dead bus lamp dark");
  property p_srcBad; (plantIn.isoClosed && !plantIn.isoLineOk) [*6] |-> lamps.breakXferLamp;
  endproperty
  a_srcBad: assert property (p_srcBad) else $error("bad source lamp dark");
  property p_failLamp; $rose(xferState == FAILED) |-> ##[1:2] lamps.xferFailLamp; endproperty
  a_failLamp: assert property (p_failLamp) else $error("fail lamp dark");
endmodule // bypass_transfer_controller_checker

bind bypass_transfer_controller bypass_transfer_controller_checker #(
  .NUM_UNITS(NUM_UNITS), .OVERLAP_CYC(OVERLAP_CYC)
) checkerInst (
  .clk(clk), .rstn(rstn), .enterBypassBtn(enterBypassBtn), .returnLoadBtn(returnLoadBtn),
  .plantIn(plantIn), .unitInBypass(unitInBypass), .bypassCloseCmd(bypassCloseCmd),
  .bypassTripCmd(bypassTripCmd), .isoCloseCmd(isoCloseCmd), .isoTripCmd(isoTripCmd),
  .lamps(lamps), .xferState(xferState)
);

/* File: tb/tb_bypass_transfer_controller.sv */
// Self-checking bench for the transfer interlock with two breaker models.
// Assumes the checker is bound; counts are shortened by parameters.
`timescale 1ns/100ps
module tb_bypass_transfer_controller;
  import bypass_xfer_pkg::*;
  logic        clk, rstn, enterBtn, returnBtn, bypLineOk, isoLineOk, outLive;
  logic        bypStuck, isoStuck, bothSeen, bypassClosed, isoClosed, seenClr;
  logic        bypassCloseCmd, bypassTripCmd, isoCloseCmd, isoTripCmd;
  logic [6:0]  units;
  lamps_t      lamps;
  xfer_state_t xferState;
  int          nErrors, nCompared, n, idx;
  int          seed = 32'h66BC96CE;

  bypass_transfer_controller #(.OVERLAP_CYC(200), .RESPONSE_CYC(50),
    .DEBOUNCE_CYC(4), .BLINK_CYC(8)) bypass_transfer_controller_inst (
    .clk(clk), .rstn(rstn), .enterBypassBtn(enterBtn), .returnLoadBtn(returnBtn),
    .plantIn({bypassClosed, isoClosed, bypLineOk, isoLineOk, outLive}),
    .unitInBypass(units), .bypassCloseCmd(bypassCloseCmd), .bypassTripCmd(bypassTripCmd),
    .isoCloseCmd(isoCloseCmd), .isoTripCmd(isoTripCmd), .lamps(lamps), .xferState(xferState));
  breaker_model breaker_model_inst (.clk(clk), .rstn(rstn),
    .closeCmd(bypassCloseCmd), .tripCmd(bypassTripCmd), .stuck(bypStuck), .closed(bypassClosed));
  breaker_model #(.INIT(1'h1)) breaker_model_inst_iso (.clk(clk), .rstn(rstn),
    .closeCmd(isoCloseCmd), .tripCmd(isoTripCmd), .stuck(isoStuck), .closed(isoClosed));

  // 250 MHz clock
  initial
  begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  // Remember any overlap during a break-before-make transfer; one driver, cleared on request
  always @(posedge clk)
    if (seenClr)
      bothSeen <= 1'h0;
    else if (bypassClosed && isoClosed)
      bothSeen <= 1'h1;

  task finalReport;
    $display("compared %0d mismatches %0d", nCompared, nErrors);
    if (nErrors == 0 && nCompared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task check(input logic [7:0] seen, input logic [7:0] exp);
    nCompared++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Operator holds the button until the opposite lamp lights, or for a fixed time
  task press(input logic ent, input int hold);
    int i;
    if (ent) enterBtn = 1'h1; else returnBtn = 1'h1;
    for (i = 0; i < 400; i++)
    begin
      @(negedge clk);
      if (hold == 0 && (ent ? lamps.returnLoadLamp : lamps.enterBypassLamp) === 1'h1) break;
      if (hold != 0 && i >= hold) break;
    end
    if (i == 400)
    begin
      nErrors++;
      $display("mismatch at %0t: transfer never completed", $time);
      finalReport();
    end
    enterBtn = 1'h0;
    returnBtn = 1'h0;
    repeat (20) @(negedge clk);
  endtask

  initial
  begin
    {rstn, enterBtn, returnBtn, bypStuck, isoStuck} = 5'h0;
    seenClr = 1'h1;
    {bypLineOk, isoLineOk, outLive} = 3'h7;
    units = 7'h7F;
    nErrors = 0;
    nCompared = 0;
    repeat (4) @(negedge clk);
    rstn = 1'h1;
    check(xferState, IDLE);
    repeat (10) @(negedge clk);
    check(lamps, 4'h8);
    // A two-cycle bounce is shorter than the debounce window and must not start a transfer
    enterBtn = 1'h1;
    repeat (2) @(negedge clk);
    enterBtn = 1'h0;
    repeat (20) @(negedge clk);
    check(xferState, IDLE);
    // Random presses with at least one unit out of bypass
    repeat (4)
    begin
      units = 7'($random(seed));
      idx = ($random(seed) & 32'h7FFF) % 7;
      units[idx] = 1'h0;
      press(1'($random(seed)), 40);
      check(bypassClosed, 1'h0);
    end
    units = 7'h7F;
    $display("refusal test done");
    press(1'h1, 0);
    check(lamps, 4'h4);
    press(1'h0, 0);
    check(lamps, 4'h8);
    $display("closed transition test done");
    // Bypass breaker never closes: fail lamp, blinking enter lamp, clear by other button
    bypStuck = 1'h1;
    press(1'h1, 120);
    check({lamps.xferFailLamp, isoClosed}, 2'h3);
    n = 0;
    repeat (40)
    begin
      idx = lamps.enterBypassLamp;
      @(negedge clk);
      if (lamps.enterBypassLamp !== 1'(idx)) n++;
    end
    check(n > 4, 1'h1);
    check(lamps.returnLoadLamp, 1'h1);
    bypStuck = 1'h0;
    press(1'h1, 40);
    check(lamps.xferFailLamp, 1'h1);
    press(1'h0, 40);
    check({lamps.xferFailLamp, xferState}, {1'h0, IDLE});
    // No close onto a dead line
    bypLineOk = 1'h0;
    press(1'h1, 120);
    check(bypassClosed, 1'h0);
    bypLineOk = 1'h1;
    press(1'h0, 40);
    check(lamps, 4'h8);
    $display("fail test done");
    isoLineOk = 1'h0;
    repeat (10) @(negedge clk);
    check(lamps.breakXferLamp, 1'h1);
    isoLineOk = 1'h1;
    outLive = 1'h0;
    repeat (10) @(negedge clk);
    check(lamps.breakXferLamp, 1'h1);
    seenClr = 1'h0;
    press(1'h1, 0);
    outLive = 1'h1;
    repeat (10) @(negedge clk);
    check(bothSeen, 1'h0);
    check(lamps, 4'h4);
    $display("break transfer test done");
    // Both breakers stuck closed: overlap timer must trip isolation breaker
    bypStuck = 1'h1;
    press(1'h0, 0);
    isoStuck = 1'h1;
    repeat (300) @(negedge clk);
    check(isoTripCmd, 1'h1);
    check(lamps.xferFailLamp, 1'h1);
    isoStuck = 1'h0;
    repeat (30) @(negedge clk);
    check(isoClosed, 1'h0);
    bypStuck = 1'h0;
    press(1'h1, 40);
    check(lamps, 4'h4);
    $display("overlap timer test done");
    finalReport();
  end
endmodule // tb_bypass_transfer_controller
